/* include/tcwd_defs.vh */
// constants for the transmit command word decoder
`ifndef TCWD_DEFS_VH
`define TCWD_DEFS_VH

// ----------------------------------------------------------------
// first command word fields
// ----------------------------------------------------------------
`define TCWD_A_RSVD_HI      31
`define TCWD_A_RSVD_LO      30
`define TCWD_A_IGMP         29
`define TCWD_A_ICMP         28
`define TCWD_A_LSO          27
`define TCWD_A_IPHDR        26
`define TCWD_A_L4           25
`define TCWD_A_VINS         24
`define TCWD_A_VOVR         23
`define TCWD_A_FCSPAD       22
`define TCWD_A_RSVD2_HI     21
`define TCWD_A_RSVD2_LO     20
`define TCWD_A_LEN_HI       19
`define TCWD_A_LEN_LO       0
`define TCWD_A_LENX_HI      19
`define TCWD_A_LENX_LO      16

// ----------------------------------------------------------------
// second command word fields
// ----------------------------------------------------------------
`define TCWD_B_RSVD_HI      31
`define TCWD_B_RSVD_LO      30
`define TCWD_B_MSS_HI       29
`define TCWD_B_MSS_LO       16
`define TCWD_B_TAG_HI       15
`define TCWD_B_TAG_LO       0
`define TCWD_TAG_PRI_HI     15
`define TCWD_TAG_PRI_LO     13
`define TCWD_TAG_CFI        12
`define TCWD_TAG_VID_HI     11
`define TCWD_TAG_VID_LO     0

// ----------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------
`define TCWD_MIN_MSS        14'h0008
`define TCWD_MIN_RAW_LEN    20'h00020
`define TCWD_MAX_PLAIN_LEN  16'h2FF7
`define TCWD_WORD_ROUND     21'h000003
`define TCWD_RST_WORD       32'h00000000
`define TCWD_RST_WCNT       19'h00000
`define TCWD_FULL_BE        4'hF
`define TCWD_FIFO_WIDTH     37
`define TCWD_FIFO_DEPTH     16
`define TCWD_FIFO_AW        4

`endif

/* core/tcwd_fifo.v */
// synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps

module tcwd_fifo
#(
	parameter WIDTH = 37,
	parameter DEPTH = 16,
	parameter AW    = 4
)
(
	// clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;
	integer         i;

	// honest flags: ready drops only when every slot holds a word
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// storage, pointers and occupancy
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop)
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				count <= count + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				count <= count - {{AW{1'b0}}, 1'b1};
		end
	end

endmodule // tcwd_fifo

/* core/tcwd_decoder.v */
// transmit command word decoder: strips two command words, delimits data
//
// How it works
// - each buffer opens with command word one, then word two, then data
// - bit 29 of word one requests the IGMP checksum
// - bit 28 of word one requests the ICMP or ICMPv6 checksum
// - bit 26 of word one requests the IP header checksum
// - bit 25 of word one requests the TCP or UDP checksum
// - all four checksum requests are dropped while large send is on
// - bit 27 requests large send segmentation at the maximum segment size
// - bit 24 requests VLAN tag insertion using the tag of word two
// - bit 23 overwrites an existing tag, else a second tag is inserted
// - bit 22 requests FCS generation and zero padding below 64 bytes
// - with bit 22 clear there is no padding and the FCS is present
// - bits 19:0 of word one are the frame byte count
// - with large send on the length is the whole large packet
// - bits 29:16 of word two are the 14-bit segment size, large send only
// - bits 15:0 of word two are the tag: priority, CANONICAL_FORMAT_FLAG, VLAN id
// - data starts right after word two and runs without gaps
// - unused trailing bytes of the last word are not sent to the MAC
// - last word byte enables follow from the low bits of the length
// - nonzero bits 31:30 of word one raise the transmit error flag
`timescale 1ns/1ps
`include "tcwd_defs.vh"

module tcwd_decoder
(
	// clock and reset
	input  wire        CLK_SYS,
	input  wire        NRST,
	// buffer words from the transmit FIFO
	input  wire [31:0] IN_DATA,
	input  wire        IN_VALID,
	output wire        IN_READY,
	// delimited frame data towards the MAC
	output wire [31:0] MAC_DATA,
	output wire [3:0]  MAC_BYTE_EN,
	output wire        MAC_LAST,
	output wire        MAC_VALID,
	input  wire        MAC_READY,
	// sideband settings of the frame now being drained
	output reg         SB_VALID,
	output reg         IGMP_CSUM_EN,
	output reg         ICMP_CSUM_EN,
	output reg         IP_HDR_CSUM_EN,
	output reg         L4_CSUM_EN,
	output reg         LARGE_SEND_EN,
	output reg         VLAN_INSERT_EN,
	output reg         VLAN_OVERWRITE_EN,
	output reg         FCS_PAD_EN,
	output reg         FCS_PRESENT,
	output reg  [19:0] FRAME_BYTE_COUNT,
	output reg  [13:0] MAX_SEGMENT_SIZE,
	output reg  [15:0] VLAN_TAG_VALUE,
	output reg  [2:0]  TAG_PRIORITY,
	output reg         CANONICAL_FORMAT_FLAG,
	output reg  [11:0] VLAN_ID,
	// status
	output reg         TRANSMIT_ERROR_FLAG
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [3:0] ST_CMD_A = 4'h1;
	localparam [3:0] ST_CMD_B = 4'h2;
	localparam [3:0] ST_DATA  = 4'h4;
	localparam [3:0] ST_ERR   = 4'h8;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	reg  [3:0]  state;
	reg  [31:0] cmd_a;
	reg  [18:0] words_left;
	reg         frame_open;
	wire        take;
	wire        large_send_en;
	wire        fcs_pad;
	wire [13:0] mss_in;
	wire [20:0] len_round;
	wire [18:0] word_total;
	wire        last_word;
	wire        cmd_bad;
	wire        fifo_in_ready;
	wire        fifo_in_valid;
	wire [36:0] fifo_in_data;
	wire [36:0] fifo_out_data;
	wire        mac_take;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// lanes kept in the closing word; lane 0 holds the earliest byte
	function [3:0] tail_lanes;
		input [1:0] len_lo;
		begin
			case (len_lo)
				2'h1:    tail_lanes = 4'h1;
				2'h2:    tail_lanes = 4'h3;
				2'h3:    tail_lanes = 4'h7;
				default: tail_lanes = `TCWD_FULL_BE;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// input handshake
	// ----------------------------------------------------------------
	// a new buffer waits until the previous frame has fully left, so
	// the sideband never changes under a frame still in the FIFO
	assign IN_READY = (state == ST_CMD_A) ? ~frame_open :
	                  (state == ST_CMD_B) ? 1'b1 :
	                  (state == ST_DATA)  ? fifo_in_ready : 1'b0;
	assign take     = IN_VALID & IN_READY;

	// fields of the held first word, and the segment size of word two on the input
	assign large_send_en     = cmd_a[`TCWD_A_LSO];
	assign fcs_pad = cmd_a[`TCWD_A_FCSPAD];
	assign mss_in  = IN_DATA[`TCWD_B_MSS_HI:`TCWD_B_MSS_LO];

	// data word count is the byte length rounded up to whole words
	assign len_round  = {1'b0, cmd_a[`TCWD_A_LEN_HI:`TCWD_A_LEN_LO]}
	                    + `TCWD_WORD_ROUND;
	assign word_total = len_round[20:2];

	// ----------------------------------------------------------------
	// sanity checks on the two command words
	// ----------------------------------------------------------------
	// any hit means the path is out of step; only a reset recovers
	assign cmd_bad =
		(|cmd_a[`TCWD_A_RSVD_HI:`TCWD_A_RSVD_LO]) |
		(|cmd_a[`TCWD_A_RSVD2_HI:`TCWD_A_RSVD2_LO]) |
		(|IN_DATA[`TCWD_B_RSVD_HI:`TCWD_B_RSVD_LO]) |
		(large_send_en & (mss_in < `TCWD_MIN_MSS)) |
		(~large_send_en & (mss_in != 14'h0000)) |
		(~large_send_en & (|cmd_a[`TCWD_A_LENX_HI:`TCWD_A_LENX_LO])) |
		(~large_send_en & (cmd_a[15:0] > `TCWD_MAX_PLAIN_LEN)) |
		(~fcs_pad & (cmd_a[`TCWD_A_LEN_HI:`TCWD_A_LEN_LO]
		             < `TCWD_MIN_RAW_LEN)) |
		(cmd_a[`TCWD_A_VOVR] & ~cmd_a[`TCWD_A_VINS]);

	// ----------------------------------------------------------------
	// data delimiting
	// ----------------------------------------------------------------
	// only data words enter the FIFO; the closing word carries trimmed
	// lanes and the last marker
	assign last_word     = (words_left == 19'h00001);
	assign fifo_in_valid = (state == ST_DATA) & IN_VALID;
	assign fifo_in_data  = {last_word,
	                        last_word ? tail_lanes(cmd_a[1:0])
	                                  : `TCWD_FULL_BE,
	                        IN_DATA};

	// frame buffer between the decoder and the MAC
	tcwd_fifo
	#(
		.WIDTH (`TCWD_FIFO_WIDTH),
		.DEPTH (`TCWD_FIFO_DEPTH),
		.AW    (`TCWD_FIFO_AW)
	)
	u_fifo
	(
		.clk       (CLK_SYS),
		.rst_n     (NRST),
		.in_data   (fifo_in_data),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (MAC_VALID),
		.out_ready (MAC_READY)
	);

	assign MAC_DATA    = fifo_out_data[31:0];
	assign MAC_BYTE_EN = fifo_out_data[35:32];
	assign MAC_LAST    = fifo_out_data[36];
	assign mac_take    = MAC_VALID & MAC_READY;

	// ----------------------------------------------------------------
	// buffer sequencer
	// ----------------------------------------------------------------
	// word one, then word two, then exactly the counted data words
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			state      <= ST_CMD_A;
			cmd_a      <= `TCWD_RST_WORD;
			words_left <= `TCWD_RST_WCNT;
		end
		else
		begin
			case (state)
				ST_CMD_A:
				begin
					if (take)
					begin
						cmd_a <= IN_DATA;
						state <= ST_CMD_B;
					end
				end
				ST_CMD_B:
				begin
					if (take)
					begin
						words_left <= word_total;
						if (cmd_bad)
							state <= ST_ERR;
						else if (word_total == `TCWD_RST_WCNT)
							state <= ST_CMD_A;
						else
							state <= ST_DATA;
					end
				end
				ST_DATA:
				begin
					if (take)
					begin
						words_left <= words_left - 19'h00001;
						if (last_word)
							state <= ST_CMD_A;
					end
				end
				// stalled for good: the input is never taken again
				ST_ERR:
					state <= ST_ERR;
				default:
					state <= ST_CMD_A;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// frame ownership and error flag
	// ----------------------------------------------------------------
	// open from word two until the MAC takes the closing word
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			frame_open          <= 1'b0;
			SB_VALID            <= 1'b0;
			TRANSMIT_ERROR_FLAG <= 1'b0;
		end
		else
		begin
			if (mac_take & MAC_LAST)
			begin
				frame_open <= 1'b0;
				SB_VALID   <= 1'b0;
			end
			else if ((state == ST_CMD_B) & take & ~cmd_bad &
			         (word_total != `TCWD_RST_WCNT))
			begin
				frame_open <= 1'b1;
				SB_VALID   <= 1'b1;
			end
			// sticky: only a reset clears it
			if ((state == ST_CMD_B) & take & cmd_bad)
				TRANSMIT_ERROR_FLAG <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// sideband settings, latched when word two is taken
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			IGMP_CSUM_EN          <= 1'b0;
			ICMP_CSUM_EN          <= 1'b0;
			IP_HDR_CSUM_EN        <= 1'b0;
			L4_CSUM_EN            <= 1'b0;
			LARGE_SEND_EN         <= 1'b0;
			VLAN_INSERT_EN        <= 1'b0;
			VLAN_OVERWRITE_EN     <= 1'b0;
			FCS_PAD_EN            <= 1'b0;
			FCS_PRESENT           <= 1'b0;
			FRAME_BYTE_COUNT      <= 20'h00000;
			MAX_SEGMENT_SIZE      <= 14'h0000;
			VLAN_TAG_VALUE        <= 16'h0000;
			TAG_PRIORITY          <= 3'h0;
			CANONICAL_FORMAT_FLAG <= 1'b0;
			VLAN_ID               <= 12'h000;
		end
		else if ((state == ST_CMD_B) & take)
		begin
			// checksum requests mean nothing during large send
			IGMP_CSUM_EN   <= cmd_a[`TCWD_A_IGMP] & ~large_send_en;
			ICMP_CSUM_EN   <= cmd_a[`TCWD_A_ICMP] & ~large_send_en;
			IP_HDR_CSUM_EN <= cmd_a[`TCWD_A_IPHDR] & ~large_send_en;
			L4_CSUM_EN     <= cmd_a[`TCWD_A_L4] & ~large_send_en;
			LARGE_SEND_EN  <= large_send_en;
			VLAN_INSERT_EN <= cmd_a[`TCWD_A_VINS];
			// overwrite only has meaning together with insertion
			VLAN_OVERWRITE_EN <= cmd_a[`TCWD_A_VOVR]
			                     & cmd_a[`TCWD_A_VINS];
			FCS_PAD_EN  <= fcs_pad;
			FCS_PRESENT <= ~fcs_pad;
			// whole large packet size when large send is on
			FRAME_BYTE_COUNT <=
				cmd_a[`TCWD_A_LEN_HI:`TCWD_A_LEN_LO];
			MAX_SEGMENT_SIZE <= large_send_en ? mss_in : 14'h0000;
			VLAN_TAG_VALUE   <=
				IN_DATA[`TCWD_B_TAG_HI:`TCWD_B_TAG_LO];
			TAG_PRIORITY <=
				IN_DATA[`TCWD_TAG_PRI_HI:`TCWD_TAG_PRI_LO];
			CANONICAL_FORMAT_FLAG <= IN_DATA[`TCWD_TAG_CFI];
			VLAN_ID <=
				IN_DATA[`TCWD_TAG_VID_HI:`TCWD_TAG_VID_LO];
		end
	end

endmodule // tcwd_decoder

/* sim/tcwd_decoder_props.sv */
// assertion checker for the command word decoder, with its bind
`timescale 1ns/1ps
module tcwd_decoder_props
(
	// clock, reset and word stream in
	input wire        CLK_SYS,
	input wire        NRST,
	input wire [31:0] IN_DATA,
	input wire        IN_VALID,
	input wire        IN_READY,
	// word stream out
	input wire [31:0] MAC_DATA,
	input wire [3:0]  MAC_BYTE_EN,
	input wire        MAC_LAST,
	input wire        MAC_VALID,
	input wire        MAC_READY,
	// sideband and status
	input wire        SB_VALID,
	input wire        IGMP_CSUM_EN,
	input wire        ICMP_CSUM_EN,
	input wire        IP_HDR_CSUM_EN,
	input wire        L4_CSUM_EN,
	input wire        LARGE_SEND_EN,
	input wire        VLAN_INSERT_EN,
	input wire        VLAN_OVERWRITE_EN,
	input wire        FCS_PAD_EN,
	input wire        FCS_PRESENT,
	input wire [19:0] FRAME_BYTE_COUNT,
	input wire [13:0] MAX_SEGMENT_SIZE,
	input wire [15:0] VLAN_TAG_VALUE,
	input wire [2:0]  TAG_PRIORITY,
	input wire        CANONICAL_FORMAT_FLAG,
	input wire [11:0] VLAN_ID,
	input wire        TRANSMIT_ERROR_FLAG
);
	reg        hb;
	reg [31:0] a;
	reg [31:0] b;
	wire       tk = IN_VALID && IN_READY;
	wire [3:0] be = (FRAME_BYTE_COUNT[1:0] == 2'h0) ? 4'hF :
		{1'b0, FRAME_BYTE_COUNT[1:0] == 2'h3, FRAME_BYTE_COUNT[1], 1'b1};
	// data is only taken while a frame is open, so outside one words alternate
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			hb <= 1'b0;
			a  <= 32'h00000000;
			b  <= 32'h00000000;
		end
		else if (tk && !SB_VALID)
		begin
			hb <= !hb;
			if (hb)
				b <= IN_DATA;
			else
				a <= IN_DATA;
		end
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	csum_gate_a: assert property (
		LARGE_SEND_EN |-> !(IGMP_CSUM_EN || ICMP_CSUM_EN || IP_HDR_CSUM_EN ||
		L4_CSUM_EN)) else $error("checksum enable with large send");
	csum_bits_a: assert property (
		$rose(SB_VALID) |-> {IGMP_CSUM_EN, ICMP_CSUM_EN, IP_HDR_CSUM_EN,
		L4_CSUM_EN} == ({a[29:28], a[26:25]} & {4{~a[27]}}))
		else $error("checksum enables wrong");
	len_lso_a: assert property (
		$rose(SB_VALID) |-> FRAME_BYTE_COUNT == a[19:0] &&
		LARGE_SEND_EN == a[27]) else $error("length or large send wrong");
	mss_field_a: assert property (
		$rose(SB_VALID) |-> MAX_SEGMENT_SIZE == (a[27] ? b[29:16] : 14'h0000))
		else $error("segment size wrong");
	vlan_tag_a: assert property (
		$rose(SB_VALID) |-> VLAN_INSERT_EN == a[24] && VLAN_TAG_VALUE == b[15:0]
		&& {TAG_PRIORITY, CANONICAL_FORMAT_FLAG, VLAN_ID} == b[15:0])
		else $error("tag fields wrong");
	vlan_ovr_a: assert property (
		$rose(SB_VALID) |-> VLAN_OVERWRITE_EN == (a[23] && a[24]))
		else $error("overwrite enable wrong");
	fcs_ctl_a: assert property (
		$rose(SB_VALID) |-> FCS_PAD_EN == a[22] && FCS_PRESENT == !a[22])
		else $error("fcs controls wrong");
	rsvd_err_a: assert property (
		tk && hb && a[31:30] != 2'h0 |=> TRANSMIT_ERROR_FLAG && !SB_VALID)
		else $error("reserved bits not flagged");
	err_stall_a: assert property (
		TRANSMIT_ERROR_FLAG |=> TRANSMIT_ERROR_FLAG && !IN_READY && !SB_VALID)
		else $error("error flag not sticky");
	last_be_a: assert property (
		MAC_VALID |-> MAC_BYTE_EN == (MAC_LAST ? be : 4'hF))
		else $error("byte enables wrong");
	mac_hold_a: assert property (
		MAC_VALID && !MAC_READY |=> MAC_VALID && $stable(MAC_DATA) &&
		$stable(MAC_LAST)) else $error("output word not held");
endmodule // tcwd_decoder_props

bind tcwd_decoder tcwd_decoder_props u_props
(
	.CLK_SYS(CLK_SYS), .NRST(NRST), .IN_DATA(IN_DATA),
	.IN_VALID(IN_VALID), .IN_READY(IN_READY), .MAC_DATA(MAC_DATA),
	.MAC_BYTE_EN(MAC_BYTE_EN), .MAC_LAST(MAC_LAST), .MAC_VALID(MAC_VALID),
	.MAC_READY(MAC_READY), .SB_VALID(SB_VALID), .IGMP_CSUM_EN(IGMP_CSUM_EN),
	.ICMP_CSUM_EN(ICMP_CSUM_EN), .IP_HDR_CSUM_EN(IP_HDR_CSUM_EN),
	.L4_CSUM_EN(L4_CSUM_EN), .LARGE_SEND_EN(LARGE_SEND_EN),
	.VLAN_INSERT_EN(VLAN_INSERT_EN), .VLAN_OVERWRITE_EN(VLAN_OVERWRITE_EN),
	.FCS_PAD_EN(FCS_PAD_EN), .FCS_PRESENT(FCS_PRESENT),
	.FRAME_BYTE_COUNT(FRAME_BYTE_COUNT), .MAX_SEGMENT_SIZE(MAX_SEGMENT_SIZE),
	.VLAN_TAG_VALUE(VLAN_TAG_VALUE), .TAG_PRIORITY(TAG_PRIORITY),
	.CANONICAL_FORMAT_FLAG(CANONICAL_FORMAT_FLAG), .VLAN_ID(VLAN_ID),
	.TRANSMIT_ERROR_FLAG(TRANSMIT_ERROR_FLAG)
);

/* sim/tcwd_host_model.sv */
// host side model: hands buffer words to the decoder in queue order
`timescale 1ns/1ps
module tcwd_host_model
(
	// clock and reset
	input wire         clk,
	input wire         rst_n,
	// word stream towards the decoder
	input wire         in_ready,
	input wire         pause,
	output reg  [31:0] in_data,
	output reg         in_valid
);
	reg [31:0] q[$];
	reg        tk = 1'b0;
	initial in_data = 32'h00000000;
	initial in_valid = 1'b0;
	task push(input [31:0] w);
		q.push_back(w);
	endtask
	// a word counts as sent only at an edge that saw ready
	always @(posedge clk)
	begin
		tk <= rst_n && in_valid && in_ready;
	end
	// strict queue order, pauses may open gaps after a taken word; a pause never withdraws a word
	always @(negedge clk)
	begin
		if (tk)
			void'(q.pop_front());
		if (rst_n && q.size() > 0 && ((in_valid && !tk) || !pause))
		begin
			in_valid = 1'b1;
			in_data  = q[0];
		end
		else
		begin
			in_valid = 1'b0;
			in_data  = ~in_data; // idle data keeps moving, never looks stale
		end
	end
endmodule // tcwd_host_model

/* sim/tcwd_decoder_test.sv */
// self-checking bench for the command word decoder
`timescale 1ns/1ps
module tcwd_decoder_test;
	reg         CLK_SYS = 1'b0;
	reg         NRST = 1'b0;
	reg         MAC_READY = 1'b0;
	reg         pause = 1'b0;
	reg         stall = 1'b0;
	reg         sb_d = 1'b0;
	reg  [31:0] rs = 32'h00000026;
	wire [31:0] IN_DATA;
	wire        IN_VALID, IN_READY, MAC_VALID, SB_VALID, TRANSMIT_ERROR_FLAG;
	wire [36:0] mw;
	wire [74:0] sb;
	reg  [36:0] wq[$];
	reg  [74:0] sq[$];
	integer     n_mismatch = 0, checked = 0, cyc = 0, i;
	reg  [31:0] opt [0:7] = '{32'h20400000, 32'h10400000, 32'h04400000,
		32'h02400000, 32'h01400000, 32'h01C00000, 32'h3E400000, 32'h00000000};
	reg  [31:0] ea [0:8] = '{32'hC0400020, 32'h00500020, 32'h00400020,
		32'h08400020, 32'h00400020, 32'h00410020, 32'h00402FF8, 32'h0000001F,
		32'h00C00020};
	reg  [31:0] eb [0:8] = '{32'h0, 32'h0, 32'h40000000, 32'h00070000,
		32'h00010000, 32'h0, 32'h0, 32'h0, 32'h0};

	tcwd_host_model u_host (.clk(CLK_SYS), .rst_n(NRST), .in_ready(IN_READY),
		.pause(pause), .in_data(IN_DATA), .in_valid(IN_VALID));
	tcwd_decoder DUT
	(
		.CLK_SYS(CLK_SYS), .NRST(NRST), .IN_DATA(IN_DATA),
		.IN_VALID(IN_VALID), .IN_READY(IN_READY),
		.MAC_DATA(mw[36:5]), .MAC_BYTE_EN(mw[4:1]), .MAC_LAST(mw[0]),
		.MAC_VALID(MAC_VALID), .MAC_READY(MAC_READY), .SB_VALID(SB_VALID),
		.IGMP_CSUM_EN(sb[74]), .ICMP_CSUM_EN(sb[73]),
		.IP_HDR_CSUM_EN(sb[72]), .L4_CSUM_EN(sb[71]),
		.LARGE_SEND_EN(sb[70]), .VLAN_INSERT_EN(sb[69]),
		.VLAN_OVERWRITE_EN(sb[68]), .FCS_PAD_EN(sb[67]),
		.FCS_PRESENT(sb[66]), .FRAME_BYTE_COUNT(sb[65:46]),
		.MAX_SEGMENT_SIZE(sb[45:32]), .VLAN_TAG_VALUE(sb[31:16]),
		.TAG_PRIORITY(sb[15:13]), .CANONICAL_FORMAT_FLAG(sb[12]),
		.VLAN_ID(sb[11:0]), .TRANSMIT_ERROR_FLAG(TRANSMIT_ERROR_FLAG)
	);

	always #50 CLK_SYS = ~CLK_SYS;
	function [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		rnd = rs;
	endfunction
	task end_of_test;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task miss(input [74:0] got);
		n_mismatch++;
		$display("CHECK FAILED %0t unexpected value %h", $time, got);
	endtask
	task cmp_w(input [36:0] got);
		checked++;
		if (wq.size() == 0 || got !== wq[0])
			miss(got);
		if (wq.size() != 0)
			void'(wq.pop_front());
	endtask
	task cmp_s(input [74:0] got);
		checked++;
		if (sq.size() == 0 || got !== sq[0])
			miss(got);
		if (sq.size() != 0)
			void'(sq.pop_front());
	endtask
	task cmp_b(input got, input exp);
		checked++;
		if (got !== exp)
			miss(got);
	endtask
	// hosts keep the reserved bits zero and the length and size limits
	task frame(input [31:0] a, input [31:0] b);
		integer k, n;
		reg [31:0] d;
		reg [3:0]  lbe;
		u_host.push(a);
		u_host.push(b);
		n = (a[19:0] + 3) / 4;
		lbe = (a[1:0] == 2'h0) ? 4'hF : 4'hF >> (3'h4 - a[1:0]);
		if (n != 0)
			sq.push_back({{a[29:28], a[26:25]} & {4{~a[27]}}, a[27], a[24],
				a[23] & a[24], a[22], ~a[22], a[19:0],
				a[27] ? b[29:16] : 14'h0000, b[15:0], b[15:0]});
		for (k = 0; k < n; k++)
		begin
			d = rnd();
			u_host.push(d);
			wq.push_back({d, (k == n - 1) ? lbe : 4'hF, k == n - 1});
		end
	endtask
	task rst;
		NRST = 1'b0;
		repeat (8) @(negedge CLK_SYS);
		NRST = 1'b1;
	endtask
	task drain;
		integer k;
		k = 0;
		while ((u_host.q.size() + wq.size() + sq.size()) != 0 && k < 4000)
		begin
			@(negedge CLK_SYS);
			k++;
		end
		// words still queued at the limit would otherwise go unchecked
		if (k >= 4000)
			n_mismatch++;
	endtask
	// random back-pressure and host gaps, changed off the sampling edge
	always @(negedge CLK_SYS)
	begin
		MAC_READY <= !stall && (rnd() % 4 != 0);
		pause <= (rnd() % 4 == 0);
	end
	// scoreboard: words as the MAC takes them, sideband as each frame opens
	always @(posedge CLK_SYS)
	begin
		sb_d <= SB_VALID;
		if (NRST && MAC_VALID && MAC_READY)
			cmp_w(mw);
		if (NRST && SB_VALID && !sb_d)
			cmp_s(sb);
			// the compare above also
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			end_of_test;
		end
	end

	initial
	begin
		rst();
		// each option once, overwrite with insert, large send with all checksums, lengths 32..39 for every trailing residue
		for (i = 0; i < 8; i++)
			// segment size 8 in bits 29:16 of word two, random tag below
			frame(opt[i] | (32 + i), (opt[i][27] ? 32'h00080000 : 32'h0) |
				(rnd() & 32'h0000FFFF));
		frame(32'h00400000, 32'h0);
		frame(32'h00400001, 32'h0);
		for (i = 0; i < 6; i++)
			frame(32'h00400000 | (rnd() % 64 + 1), rnd() & 32'hFFFF);
		drain();
		// hold the MAC off so the buffer fills and refuses further words
		stall = 1'b1;
		frame(32'h00400050, 32'h0);
		repeat (40) @(negedge CLK_SYS);
		cmp_b(IN_READY, 1'b0);
		cmp_b(MAC_VALID, 1'b1);
		stall = 1'b0;
		drain();
		// each malformed header stalls the path with the flag up
		for (i = 0; i < 9; i++)
		begin
			rst();
			u_host.push(ea[i]);
			u_host.push(eb[i]);
			repeat (6) @(negedge CLK_SYS);
			cmp_b(TRANSMIT_ERROR_FLAG, 1'b1);
			cmp_b(IN_READY, 1'b0);
		end
		end_of_test;
	end
endmodule // tcwd_decoder_test
